// File: design/bvr_ctrl.sv
// bvr_ctrl: bridge control upper half, vga decode, abort mode, sec reset.
// assumes config cycles and transaction decode strobes on core_clk.
//
// What this block does
// [RQ1] with vga enable clear, vga-range primary cycles are claimed only via the i/o window with isa mode off.
// [RQ2] with vga enable set, primary memory cycles at 000A0000h-000BFFFFh are claimed and forwarded.
// [RQ3] with vga enable set, primary i/o at 3B0h-3BBh or 3C0h-3DFh with bits 31:16 zero is claimed.
// [RQ4] software sets both i/o and memory space enables for vga forwarding to work.
// [RQ5] vga memory and i/o ranges are never claimed on the secondary bus while vga enable is set.
// [RQ6] bit 20 is reserved and always reads as zero.
// [RQ7] with abort mode clear, a master-aborted delayed cycle completes with trdy, reads give all ones.
// [RQ8] with abort mode clear, a master-aborted posted write raises no system error.
// [RQ9] with abort mode set, a master-aborted delayed cycle ends in target abort.
// [RQ10] with abort mode set, a master-aborted posted write raises system error if serr enable is on.
// [RQ11] the secondary reset pin follows the secondary bus reset bit.
// [RQ12] while secondary reset is asserted, buffers and secondary logic are held in reset.
// [RQ13] secondary reset leaves primary logic and configuration contents unchanged.
// [RQ14] vga enable, abort mode and secondary reset bits clear on device reset.
`timescale 1ns/100ps
module bvr_ctrl
  import bvr_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // configuration access
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [5:0] cfg_dword,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata_reg,
  output logic cfg_rvalid_reg,
  // command register and window state
  input wire logic cmd_io_en,
  input wire logic cmd_mem_en,
  input wire logic cmd_serr_en,
  input wire logic isa_mode,
  input wire logic p_io_win_hit,
  input wire logic s_io_win_hit,
  // primary transaction decode
  input wire logic p_valid,
  input wire logic p_is_mem,
  input wire logic p_is_io,
  input wire logic [31:0] p_addr,
  output logic p_claim_reg,
  output logic p_vga_reg,
  // secondary transaction decode
  input wire logic s_valid,
  input wire logic s_is_mem,
  input wire logic s_is_io,
  input wire logic [31:0] s_addr,
  output logic s_claim_reg,
  // master abort of a bridge-initiated cycle
  input wire logic ma_event,
  input wire logic ma_posted,
  input wire logic ma_read,
  output logic dt_trdy_reg,
  output logic dt_tabort_reg,
  output logic [31:0] dt_rdata_reg,
  output logic p_serr_reg,
  // secondary reset
  output logic s_rst_n_reg,
  output logic sec_logic_rst_reg
);

  // ----------------------------------------------------------------
  // control bits
  // ----------------------------------------------------------------
  logic vga_en_reg;
  logic ma_mode_reg;
  logic sbr_reg;

  wire logic bctl_sel = (cfg_dword == BVR_BCTL_DWORD);
  wire logic ctl_wr = cfg_wr & bctl_sel & cfg_be[BVR_CTL_BYTE];
  wire logic vga_en_next = ctl_wr ? cfg_wdata[BVR_VGA_EN_BIT] : vga_en_reg;
  wire logic ma_mode_next = ctl_wr ? cfg_wdata[BVR_MA_MODE_BIT] : ma_mode_reg;
  wire logic sbr_next = ctl_wr ? cfg_wdata[BVR_SBR_BIT] : sbr_reg;

  // only the device reset touches these; the secondary reset never does
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      vga_en_reg <= BVR_VGA_EN_RST;   // [RQ14]
      ma_mode_reg <= BVR_MA_MODE_RST; // [RQ14]
      sbr_reg <= BVR_SBR_RST;         // [RQ14]
    end else begin
      vga_en_reg <= vga_en_next;      // [RQ13]
      ma_mode_reg <= ma_mode_next;
      sbr_reg <= sbr_next;
    end
  end

  // ----------------------------------------------------------------
  // configuration read
  // ----------------------------------------------------------------
  logic [31:0] bctl_word;
  always_comb begin
    bctl_word = 32'h0000_0000;
    bctl_word[BVR_VGA_EN_BIT] = vga_en_reg;
    bctl_word[BVR_RSVD_BIT] = 1'b0; // [RQ6]
    bctl_word[BVR_MA_MODE_BIT] = ma_mode_reg;
    bctl_word[BVR_SBR_BIT] = sbr_reg;
  end

  // unmapped dwords and bits not held here read as zero
  wire logic [31:0] rdata_next = (cfg_rd & bctl_sel) ? bctl_word : 32'h0000_0000;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_rdata_reg <= 32'h0000_0000;
      cfg_rvalid_reg <= 1'b0;
    end else begin
      cfg_rdata_reg <= rdata_next;
      cfg_rvalid_reg <= cfg_rd;
    end
  end

  // ----------------------------------------------------------------
  // primary decode
  // ----------------------------------------------------------------
  wire logic p_vga = bvr_vga_hit(p_addr, p_is_mem, p_is_io);
  // forwarding needs both space enables; software must set them
  wire logic vga_on = vga_en_reg & cmd_io_en & cmd_mem_en; // [RQ4]
  wire logic p_vga_claim = p_valid & p_vga & vga_on;       // [RQ2] [RQ3]
  // base/limit path, with isa mode withholding the whole i/o window
  wire logic p_win_claim = p_valid & p_is_io & cmd_io_en & p_io_win_hit & ~isa_mode; // [RQ1]
  wire logic p_claim_next = p_vga_claim | p_win_claim;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      p_claim_reg <= 1'b0;
      p_vga_reg <= 1'b0;
    end else begin
      p_claim_reg <= p_claim_next;
      p_vga_reg <= p_vga_claim;
    end
  end

  // ----------------------------------------------------------------
  // secondary decode
  // ----------------------------------------------------------------
  wire logic s_vga = bvr_vga_hit(s_addr, s_is_mem, s_is_io);
  // upstream claim comes from outside the i/o window only
  wire logic s_up = s_valid & s_is_io & ~s_io_win_hit;
  wire logic s_block = vga_en_reg & s_vga;                 // [RQ5]
  // the secondary side is idle while its reset is asserted
  wire logic s_claim_next = s_up & ~s_block & ~sbr_reg;    // [RQ5] [RQ12]

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_claim_reg <= 1'b0;
    end else begin
      s_claim_reg <= s_claim_next;
    end
  end

  // ----------------------------------------------------------------
  // secondary reset
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_rst_n_reg <= 1'b0;
      sec_logic_rst_reg <= 1'b1;
    end else begin
      s_rst_n_reg <= ~sbr_reg;      // [RQ11]
      sec_logic_rst_reg <= sbr_reg; // [RQ12]
    end
  end

  // ----------------------------------------------------------------
  // master abort answer
  // ----------------------------------------------------------------
  // a pending abort is dropped with the buffers when secondary reset hits
  bvr_abort_resp u_abort (
    .core_clk(core_clk),
    .rst(rst),
    .sec_rst(sbr_reg),
    .ma_mode(ma_mode_reg),
    .serr_en(cmd_serr_en),
    .ma_event(ma_event),
    .ma_posted(ma_posted),
    .ma_read(ma_read),
    .dt_trdy_reg(dt_trdy_reg),
    .dt_tabort_reg(dt_tabort_reg),
    .dt_rdata_reg(dt_rdata_reg),
    .p_serr_reg(p_serr_reg)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  vga_off_claim_a: assert property ( // [RQ1]
    @(posedge core_clk) disable iff (rst)
    (p_valid & ~vga_en_reg & p_vga & ~(p_is_io & p_io_win_hit & ~isa_mode))
      |=> !p_claim_reg)
    else $error("vga cycle claimed with vga enable clear");

  vga_mem_claim_a: assert property ( // [RQ2]
    @(posedge core_clk) disable iff (rst)
    (p_valid & p_is_mem & vga_on & (p_addr >= BVR_VGA_MEM_LO) & (p_addr <= BVR_VGA_MEM_HI))
      |=> p_claim_reg && p_vga_reg)
    else $error("vga memory cycle not claimed");

  vga_io_claim_a: assert property ( // [RQ3]
    @(posedge core_clk) disable iff (rst)
    (p_valid & p_is_io & vga_on & (p_addr[31:16] == BVR_IO_UPPER)
      & (p_addr[9:0] >= BVR_VGA_IO2_LO) & (p_addr[9:0] <= BVR_VGA_IO2_HI))
      |=> p_claim_reg)
    else $error("vga i/o cycle not claimed");

  sec_vga_block_a: assert property ( // [RQ5]
    @(posedge core_clk) disable iff (rst)
    (s_valid & s_vga & vga_en_reg) |=> !s_claim_reg)
    else $error("vga range claimed on secondary");

  rsvd_read_zero_a: assert property ( // [RQ6]
    @(posedge core_clk) disable iff (rst)
    cfg_rvalid_reg |-> !cfg_rdata_reg[BVR_RSVD_BIT])
    else $error("reserved bit read as one");

  ma_trdy_data_a: assert property ( // [RQ7]
    @(posedge core_clk) disable iff (rst)
    (ma_event & ~ma_posted & ma_read & ~ma_mode_reg & ~sbr_reg)
      |=> dt_trdy_reg && (dt_rdata_reg == BVR_MA_RDATA) && !dt_tabort_reg)
    else $error("abort read did not complete with all ones");

  ma_posted_quiet_a: assert property ( // [RQ8]
    @(posedge core_clk) disable iff (rst)
    (ma_event & ma_posted & ~ma_mode_reg) |=> !p_serr_reg)
    else $error("system error raised with abort mode clear");

  ma_tabort_a: assert property ( // [RQ9]
    @(posedge core_clk) disable iff (rst)
    (ma_event & ~ma_posted & ma_mode_reg & ~sbr_reg) |=> dt_tabort_reg && !dt_trdy_reg)
    else $error("target abort missing");

  ma_serr_a: assert property ( // [RQ10]
    @(posedge core_clk) disable iff (rst)
    (ma_event & ma_posted & ma_mode_reg & ~sbr_reg)
      |=> (p_serr_reg == $past(cmd_serr_en)))
    else $error("system error does not follow serr enable");

  sec_reset_pin_a: assert property ( // [RQ11]
    @(posedge core_clk) disable iff (rst)
    (ctl_wr ##1 1'b1) |=> (s_rst_n_reg == !$past(cfg_wdata[BVR_SBR_BIT], 2)))
    else $error("secondary reset pin does not follow its bit");

  sec_logic_hold_a: assert property ( // [RQ12]
    @(posedge core_clk) disable iff (rst)
    (sbr_reg & !s_rst_n_reg) |-> sec_logic_rst_reg && !s_claim_reg)
    else $error("secondary logic active during secondary reset");

  cfg_keep_a: assert property ( // [RQ13]
    @(posedge core_clk) disable iff (rst)
    (sbr_reg & ~ctl_wr) |=> (vga_en_reg == $past(vga_en_reg))
      && (ma_mode_reg == $past(ma_mode_reg)))
    else $error("configuration changed by secondary reset");

  reset_clear_a: assert property ( // [RQ14]
    @(posedge core_clk)
    rst |=> !vga_en_reg && !ma_mode_reg && !sbr_reg)
    else $error("control bits not cleared by reset");

endmodule

// File: common/bvr_pkg.sv
// bvr_pkg: constants for the bridge control upper-half logic
// (vga forwarding, master abort mode, secondary bus reset).
// assumes a 32-bit pci configuration data path, dword addressed.
package bvr_pkg;

  // ----------------------------------------------------------------
  // configuration map
  // ----------------------------------------------------------------
  localparam logic [5:0] BVR_BCTL_DWORD = 6'h0F;  // byte offset 3Ch
  localparam int BVR_VGA_EN_BIT = 19;
  localparam int BVR_RSVD_BIT = 20;
  localparam int BVR_MA_MODE_BIT = 21;
  localparam int BVR_SBR_BIT = 22;
  localparam int BVR_CTL_BYTE = 2;
  localparam int BVR_CTL_LSB = 16;
  localparam logic BVR_VGA_EN_RST = 1'h0;
  localparam logic BVR_MA_MODE_RST = 1'h0;
  localparam logic BVR_SBR_RST = 1'h0;

  // ----------------------------------------------------------------
  // legacy vga ranges
  // ----------------------------------------------------------------
  localparam logic [31:0] BVR_VGA_MEM_LO = 32'h000A_0000;
  localparam logic [31:0] BVR_VGA_MEM_HI = 32'h000B_FFFF;
  localparam logic [9:0] BVR_VGA_IO1_LO = 10'h3B0;
  localparam logic [9:0] BVR_VGA_IO1_HI = 10'h3BB;
  localparam logic [9:0] BVR_VGA_IO2_LO = 10'h3C0;
  localparam logic [9:0] BVR_VGA_IO2_HI = 10'h3DF;
  localparam logic [15:0] BVR_IO_UPPER = 16'h0000;

  // ----------------------------------------------------------------
  // master abort answer
  // ----------------------------------------------------------------
  localparam logic [31:0] BVR_MA_RDATA = 32'hFFFF_FFFF;

  // vga hit for a memory or i/o address
  function automatic logic bvr_vga_hit(input logic [31:0] a, input logic is_mem,
                                       input logic is_io);
    logic mem_hit;
    logic io_hit;
    mem_hit = (a >= BVR_VGA_MEM_LO) && (a <= BVR_VGA_MEM_HI);
    io_hit = (a[31:16] == BVR_IO_UPPER) &&
             (((a[9:0] >= BVR_VGA_IO1_LO) && (a[9:0] <= BVR_VGA_IO1_HI)) ||
              ((a[9:0] >= BVR_VGA_IO2_LO) && (a[9:0] <= BVR_VGA_IO2_HI)));
    return (is_mem && mem_hit) || (is_io && io_hit);
  endfunction

endpackage

// File: design/bvr_abort_resp.sv
// bvr_abort_resp: answers a master abort on a bridge-initiated cycle.
// assumes one-cycle event strobes from the bridge master state machines.
`timescale 1ns/100ps
module bvr_abort_resp
  import bvr_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sec_rst,
  // controls
  input wire logic ma_mode,
  input wire logic serr_en,
  // abort event
  input wire logic ma_event,
  input wire logic ma_posted,
  input wire logic ma_read,
  // answers
  output logic dt_trdy_reg,
  output logic dt_tabort_reg,
  output logic [31:0] dt_rdata_reg,
  output logic p_serr_reg
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire logic ev = ma_event & ~sec_rst;
  wire logic dt_ev = ev & ~ma_posted;
  wire logic trdy_next = dt_ev & ~ma_mode;
  wire logic tabort_next = dt_ev & ma_mode;
  wire logic serr_next = ev & ma_posted & ma_mode & serr_en;
  // only reads get the all-ones word; write completions carry no data
  wire logic [31:0] rdata_next = (trdy_next & ma_read) ? BVR_MA_RDATA : 32'h0000_0000;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dt_trdy_reg <= 1'b0;
      dt_tabort_reg <= 1'b0;
      dt_rdata_reg <= 32'h0000_0000;
      p_serr_reg <= 1'b0;
    end else begin
      dt_trdy_reg <= trdy_next;     // [RQ7]
      dt_rdata_reg <= rdata_next;   // [RQ7]
      dt_tabort_reg <= tabort_next; // [RQ9]
      p_serr_reg <= serr_next;      // [RQ8] [RQ10]
    end
  end

endmodule

// File: test/bvr_far_model.sv
// bvr_far_model: far-bus target that never answers, so each cycle the
// bridge starts there ends in master abort. assumes core_clk rising edge.
`timescale 1ns/100ps
module bvr_far_model (
  // clock
  input wire logic core_clk,
  // abort report
  output logic ma_event,
  output logic ma_posted,
  output logic ma_read
);
  initial begin
    ma_event = 1'h0;
    ma_posted = 1'h0;
    ma_read = 1'h0;
  end
  // qualifiers flip once idle so nothing relies on stale values
  task automatic abort(input logic posted, input logic rd);
    @(posedge core_clk);
    #1;
    ma_event = 1'h1;
    ma_posted = posted;
    ma_read = rd;
    @(posedge core_clk);
    #1;
    ma_event = 1'h0;
    ma_posted = ~posted;
    ma_read = ~rd;
  endtask
endmodule

// File: test/bvr_ctrl_tb_top.sv
// bvr_ctrl_tb_top: self-checking bench for the bridge control upper half.
// assumes bvr_ctrl and the far-bus model; inputs move 1 ns after edges.
`timescale 1ns/100ps
module bvr_ctrl_tb_top
  import bvr_pkg::*;
;
  logic core_clk, rst, cfg_wr, cfg_rd, cfg_rvalid_reg;
  logic [5:0] cfg_dword;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata_reg, p_addr, s_addr, dt_rdata_reg;
  logic cmd_io_en, cmd_mem_en, cmd_serr_en, isa_mode, p_io_win_hit, s_io_win_hit;
  logic p_valid, p_is_mem, p_is_io, p_claim_reg, p_vga_reg;
  logic s_valid, s_is_mem, s_is_io, s_claim_reg;
  logic ma_event, ma_posted, ma_read, dt_trdy_reg, dt_tabort_reg, p_serr_reg;
  logic s_rst_n_reg, sec_logic_rst_reg;
  int n_fail = 0;
  int compares = 0;

  bvr_ctrl bvr_ctrl_inst (
    .core_clk(core_clk),
    .rst(rst),
    .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd),
    .cfg_dword(cfg_dword),
    .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata),
    .cfg_rdata_reg(cfg_rdata_reg),
    .cfg_rvalid_reg(cfg_rvalid_reg),
    .cmd_io_en(cmd_io_en),
    .cmd_mem_en(cmd_mem_en),
    .cmd_serr_en(cmd_serr_en),
    .isa_mode(isa_mode),
    .p_io_win_hit(p_io_win_hit),
    .s_io_win_hit(s_io_win_hit),
    .p_valid(p_valid),
    .p_is_mem(p_is_mem),
    .p_is_io(p_is_io),
    .p_addr(p_addr),
    .p_claim_reg(p_claim_reg),
    .p_vga_reg(p_vga_reg),
    .s_valid(s_valid),
    .s_is_mem(s_is_mem),
    .s_is_io(s_is_io),
    .s_addr(s_addr),
    .s_claim_reg(s_claim_reg),
    .ma_event(ma_event),
    .ma_posted(ma_posted),
    .ma_read(ma_read),
    .dt_trdy_reg(dt_trdy_reg),
    .dt_tabort_reg(dt_tabort_reg),
    .dt_rdata_reg(dt_rdata_reg),
    .p_serr_reg(p_serr_reg),
    .s_rst_n_reg(s_rst_n_reg),
    .sec_logic_rst_reg(sec_logic_rst_reg)
  );
  bvr_far_model bvr_far_model_inst (.core_clk(core_clk), .ma_event(ma_event),
    .ma_posted(ma_posted), .ma_read(ma_read));

  // ----------------------------------------------------------------
  // compare and bus tasks
  // ----------------------------------------------------------------
  task automatic chk_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic cfg_write(input logic [3:0] be, input logic [31:0] d);
    @(posedge core_clk);
    #1;
    {cfg_wr, cfg_dword, cfg_be, cfg_wdata} = {1'h1, BVR_BCTL_DWORD, be, d};
    @(posedge core_clk);
    #1;
    {cfg_wr, cfg_wdata} = {1'h0, ~d};
  endtask
  task automatic cfg_read(input logic [31:0] exp);
    @(posedge core_clk);
    #1;
    {cfg_rd, cfg_dword} = {1'h1, BVR_BCTL_DWORD};
    @(posedge core_clk);
    #1;
    cfg_rd = 1'h0;
    chk_bit("cfg_rvalid_reg", 1'h1, cfg_rvalid_reg);
    chk_word("cfg_rdata_reg", exp, cfg_rdata_reg);
  endtask
  task automatic pdec(input logic io, input logic [31:0] a, input logic clm, input logic vga);
    @(posedge core_clk);
    #1;
    {p_valid, p_is_mem, p_is_io, p_addr} = {1'h1, ~io, io, a};
    @(posedge core_clk);
    #1;
    {p_valid, p_addr} = {1'h0, ~a};
    chk_bit("p_claim_reg", clm, p_claim_reg);
    chk_bit("p_vga_reg", vga, p_vga_reg);
  endtask
  task automatic sdec(input logic io, input logic [31:0] a, input logic clm);
    @(posedge core_clk);
    #1;
    {s_valid, s_is_mem, s_is_io, s_addr} = {1'h1, ~io, io, a};
    @(posedge core_clk);
    #1;
    {s_valid, s_addr} = {1'h0, ~a};
    chk_bit("s_claim_reg", clm, s_claim_reg);
  endtask
  task automatic ab(input logic pw, input logic rd, input logic [3:0] exp);
    bvr_far_model_inst.abort(pw, rd);
    chk_bit("dt_trdy_reg", exp[3], dt_trdy_reg);
    chk_bit("dt_tabort_reg", exp[2], dt_tabort_reg);
    chk_bit("p_serr_reg", exp[1], p_serr_reg);
    chk_word("dt_rdata_reg", {32{exp[0]}}, dt_rdata_reg);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_cfg();
    // the pin leaves reset one edge after release
    @(posedge core_clk);
    #1;
    chk_bit("s_rst_n_reg", 1'h1, s_rst_n_reg);
    cfg_read(32'h0);
    cfg_write(4'hB, 32'hFFFF_FFFF);
    cfg_read(32'h0);
    cfg_write(4'h4, 32'hFFFF_FFFF);
    cfg_read(32'h0068_0000);
    chk_bit("s_rst_n_reg", 1'h0, s_rst_n_reg);
    chk_bit("sec_logic_rst_reg", 1'h1, sec_logic_rst_reg);
    sdec(1'h1, 32'h0000_1000, 1'h0);
    ab(1'h0, 1'h1, 4'h0);
    rst = 1'h1;
    repeat (3) @(posedge core_clk);
    #1 rst = 1'h0;
    cfg_read(32'h0);
    $display("test cfg done");
  endtask
  task automatic t_vga();
    {cmd_io_en, cmd_mem_en, p_io_win_hit} = 3'h7;
    pdec(1'h0, 32'h000A_0000, 1'h0, 1'h0);
    pdec(1'h1, 32'h0000_03C0, 1'h1, 1'h0);
    isa_mode = 1'h1;
    pdec(1'h1, 32'h0000_03C0, 1'h0, 1'h0);
    p_io_win_hit = 1'h0;
    cfg_write(4'h4, 32'h0008_0000);
    pdec(1'h0, 32'h000A_0000, 1'h1, 1'h1);
    pdec(1'h0, 32'h000B_FFFF, 1'h1, 1'h1);
    pdec(1'h0, 32'h0009_FFFF, 1'h0, 1'h0);
    pdec(1'h0, 32'h000C_0000, 1'h0, 1'h0);
    pdec(1'h1, 32'h0000_03B0, 1'h1, 1'h1);
    pdec(1'h1, 32'h0000_FFBB, 1'h1, 1'h1);
    pdec(1'h1, 32'h0000_03BC, 1'h0, 1'h0);
    pdec(1'h1, 32'h0000_07DF, 1'h1, 1'h1);
    pdec(1'h1, 32'h0001_03C0, 1'h0, 1'h0);
    sdec(1'h1, 32'h0000_03C0, 1'h0);
    sdec(1'h0, 32'h000A_0000, 1'h0);
    sdec(1'h1, 32'h0000_1000, 1'h1);
    cmd_mem_en = 1'h0;
    pdec(1'h0, 32'h000A_0000, 1'h0, 1'h0);
    cmd_mem_en = 1'h1;
    cfg_write(4'h4, 32'h0048_0000);
    pdec(1'h0, 32'h000A_0000, 1'h1, 1'h1);
    cfg_read(32'h0048_0000);
    cfg_write(4'h4, 32'h0);
    @(posedge core_clk);
    #1;
    chk_bit("s_rst_n_reg", 1'h1, s_rst_n_reg);
    chk_bit("sec_logic_rst_reg", 1'h0, sec_logic_rst_reg);
    $display("test vga done");
  endtask
  task automatic t_abort();
    cmd_serr_en = 1'h1;
    ab(1'h0, 1'h1, 4'h9);
    ab(1'h0, 1'h0, 4'h8);
    ab(1'h1, 1'h0, 4'h0);
    cfg_write(4'h4, 32'h0020_0000);
    ab(1'h0, 1'h1, 4'h4);
    ab(1'h1, 1'h0, 4'h2);
    cmd_serr_en = 1'h0;
    ab(1'h1, 1'h0, 4'h0);
    $display("test abort done");
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'h0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    #40000;
    n_fail++;
    give_verdict();
  end
  initial begin
    {rst, cfg_wr, cfg_rd, cfg_dword, cfg_be, cfg_wdata} = {1'h1, 44'h0};
    {cmd_io_en, cmd_mem_en, cmd_serr_en, isa_mode, p_io_win_hit, s_io_win_hit} = 6'h0;
    {p_valid, p_is_mem, p_is_io, p_addr, s_valid, s_is_mem, s_is_io, s_addr} = 70'h0;
    repeat (16) @(posedge core_clk);
    #1 rst = 1'h0;
    t_cfg();
    t_vga();
    t_abort();
    give_verdict();
  end
endmodule
